// ===== src/eip_unit.sv
// External interrupt pin unit: request latch, control registers, pin sharing
`include "eip_consts.svh"
`default_nettype none
module eip_unit (
  input  wire logic           clk_sys_i,             // System bus clock
  input  wire logic           rst_i,                 // Synchronous reset
  input  wire eip_pkg::eip_addr_t addr_i,            // Register address
  input  wire eip_pkg::eip_data_t wdata_i,           // Register write data
  input  wire logic           wr_i,                  // Write strobe
  input  wire logic           rd_i,                  // Read strobe
  output logic [7:0]          rdata_o,               // Read data, next cycle
  input  wire logic           ext_int_pin_n_i,       // Active-low pin
  input  wire logic           vector_fetch_ack_i,    // Core fetched vector
  input  wire logic           break_state_i,         // Debug break active
  input  wire logic           wait_mode_i,           // Core in wait mode
  input  wire logic           stop_mode_i,           // Core in stop mode
  output logic                irq_request_o,         // Request to the core
  output logic                wakeup_o,              // Leave wait or stop
  output logic                branch_pin_level_o,    // Level for pin branches
  output logic                pullup_enable_o,       // Internal pull-up on
  output logic                ext_int_pin_function_enable_o // Pin owned
);
  import eip_pkg::*;

  // Control registers
  eip_trig_t  trig_mode;        // Trigger sensitivity
  eip_trig_t  next_trig_mode;
  logic       req_mask;         // Request mask
  logic       next_req_mask;
  logic       pullup_disable;   // Pull-up disable
  logic       next_pullup_disable;
  logic       func_enable;      // Pin function enable
  logic       next_func_enable;
  logic       break_clear_enable; // Status clear allowed in break
  logic       next_break_clear_enable;

  // Request latch
  logic       req_latch;
  logic       next_req_latch;

  // Pin synchroniser and edge history
  logic       pin_meta;         // First stage, read only by pin_sync
  logic       pin_sync;         // Second stage, safe to use
  logic       pin_prev;         // Previous synchronised sample
  logic       next_pin_meta;
  logic       next_pin_sync;
  logic       next_pin_prev;

  // Read data register
  logic [7:0] next_rdata;

  // Decoded events
  logic       falling_edge;
  logic       low_level;
  logic       set_event;
  logic       ack_write;
  logic       sw_clear_ok;
  logic       clear_event;

  // Pin synchroniser; idles high so reset never looks like an edge
  always_comb begin
    next_pin_meta = ext_int_pin_n_i;
    next_pin_sync = pin_meta;
    next_pin_prev = pin_sync;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_meta <= `EIP_RST_SYNC;
      pin_sync <= `EIP_RST_SYNC;
      pin_prev <= `EIP_RST_SYNC;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      pin_prev <= next_pin_prev;
    end
  end

  // Trigger qualification; a disabled function sees nothing
  always_comb begin
    falling_edge = pin_prev & ~pin_sync;
    low_level    = (trig_mode == EIP_TRIG_FALL_LEVEL)
                   & ~pin_sync;
    set_event    = func_enable & (falling_edge | low_level);
  end

  // Clear sources for the latch
  always_comb begin
    ack_write   = wr_i && (addr_i == `EIP_OFS_STATUS_CONTROL)
                  && wdata_i[`EIP_BIT_ACK];
    // Break protects status unless clear enable is set
    sw_clear_ok = ~break_state_i | break_clear_enable;
    clear_event = vector_fetch_ack_i
                  | (ack_write & sw_clear_ok);
  end

  // Latch next value; a new event beats a same-cycle clear
  always_comb begin
    next_req_latch = req_latch;
    if (set_event) begin
      next_req_latch = 1'b1;
    end else if (clear_event) begin
      next_req_latch = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      req_latch <= `EIP_RST_LATCH;
    end else begin
      req_latch <= next_req_latch;
    end
  end

  // Control register writes; these are not status, so break has no say
  always_comb begin
    next_trig_mode          = trig_mode;
    next_req_mask           = req_mask;
    next_pullup_disable     = pullup_disable;
    next_func_enable        = func_enable;
    next_break_clear_enable = break_clear_enable;
    if (wr_i) begin
      unique case (addr_i)
        `EIP_OFS_STATUS_CONTROL: begin
          next_trig_mode = eip_trig_t'(wdata_i[`EIP_BIT_MODE]);
          next_req_mask  = wdata_i[`EIP_BIT_MASK];
        end
        `EIP_OFS_SECOND_CONFIG: begin
          next_pullup_disable = wdata_i[`EIP_BIT_PULLUP_DIS];
          next_func_enable    = wdata_i[`EIP_BIT_FUNC_EN];
        end
        `EIP_OFS_BREAK_FLAG: begin
          next_break_clear_enable = wdata_i[`EIP_BIT_BREAK_CLEAR_ENABLE];
        end
        default: begin
          // Port data and unmapped offsets hold no writable state here
          next_trig_mode = trig_mode;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      trig_mode          <= eip_trig_t'(`EIP_RST_MODE);
      req_mask           <= `EIP_RST_MASK;
      pullup_disable     <= `EIP_RST_PULLUP_DIS;
      func_enable        <= `EIP_RST_FUNC_EN;
      break_clear_enable <= `EIP_RST_BREAK_CLEAR_ENABLE;
    end else begin
      trig_mode          <= next_trig_mode;
      req_mask           <= next_req_mask;
      pullup_disable     <= next_pullup_disable;
      func_enable        <= next_func_enable;
      break_clear_enable <= next_break_clear_enable;
    end
  end

  // Read mux; reads have no side effects, so break reads are harmless
  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        `EIP_OFS_STATUS_CONTROL: begin
          next_rdata[`EIP_BIT_MODE]    = trig_mode;
          next_rdata[`EIP_BIT_MASK]    = req_mask;
          next_rdata[`EIP_BIT_ACK]     = 1'b0;
          next_rdata[`EIP_BIT_PENDING] = req_latch;
        end
        `EIP_OFS_SECOND_CONFIG: begin
          next_rdata[`EIP_BIT_PULLUP_DIS] = pullup_disable;
          next_rdata[`EIP_BIT_FUNC_EN]    = func_enable;
        end
        `EIP_OFS_BREAK_FLAG: begin
          next_rdata[`EIP_BIT_BREAK_CLEAR_ENABLE] = break_clear_enable;
        end
        `EIP_OFS_PORT_DATA: begin
          // Pin owned by the interrupt: port bit reads zero
          next_rdata[`EIP_BIT_PORT_PIN] = ~func_enable
                                          & pin_sync;
        end
        default: begin
          // Unmapped offsets read as zero
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= `EIP_RST_RDATA;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Outputs to the core and pad; the latch keeps running in wait and stop
  always_comb begin
    irq_request_o      = req_latch & ~req_mask;
    wakeup_o           = irq_request_o
                         & (wait_mode_i | stop_mode_i);
    branch_pin_level_o = func_enable ? pin_sync : 1'b1;
    pullup_enable_o    = ~pullup_disable;
    ext_int_pin_function_enable_o = func_enable;
  end

endmodule
`default_nettype wire

// ===== src/eip_consts.svh
// Offsets, field positions and reset values of the external interrupt unit
`ifndef EIP_CONSTS_SVH
`define EIP_CONSTS_SVH

// Register offsets on the plain register port
`define EIP_OFS_STATUS_CONTROL 4'h0
`define EIP_OFS_SECOND_CONFIG  4'h1
`define EIP_OFS_BREAK_FLAG     4'h2
`define EIP_OFS_PORT_DATA      4'h3

// Status and control field positions
`define EIP_BIT_MODE    0
`define EIP_BIT_MASK    1
`define EIP_BIT_ACK     2
`define EIP_BIT_PENDING 3

// Second configuration register field positions
`define EIP_BIT_PULLUP_DIS 0
`define EIP_BIT_FUNC_EN    1

// Break flag control field position
`define EIP_BIT_BREAK_CLEAR_ENABLE 7

// Shared port data bit that the pin occupies
`define EIP_BIT_PORT_PIN 2

// Reset values
`define EIP_RST_MODE       1'b0
`define EIP_RST_MASK       1'b0
`define EIP_RST_PULLUP_DIS 1'b0
`define EIP_RST_FUNC_EN    1'b0
`define EIP_RST_BREAK_CLEAR_ENABLE       1'b0
`define EIP_RST_LATCH      1'b0
`define EIP_RST_RDATA      8'h00
`define EIP_RST_SYNC       1'b1

`endif

// ===== src/eip_pkg.sv
// Types shared by the external interrupt pin unit
`default_nettype none
package eip_pkg;
  // Trigger sensitivity of the pin
  typedef enum logic [0:0] {
    EIP_TRIG_FALL_ONLY  = 1'b0,
    EIP_TRIG_FALL_LEVEL = 1'b1
  } eip_trig_t;

  // Register port widths
  typedef logic [3:0] eip_addr_t;
  typedef logic [7:0] eip_data_t;
endpackage
`default_nettype wire

// ===== testbench/eip_unit_sva.sv
// Bound checker for the external interrupt pin unit ports
`include "eip_consts.svh"
`default_nettype none
module eip_unit_sva (
  input wire logic               clk_sys_i,
  input wire logic               rst_i,
  input wire eip_pkg::eip_addr_t addr_i,
  input wire eip_pkg::eip_data_t wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [7:0]         rdata_o,
  input wire logic               ext_int_pin_n_i,
  input wire logic               wait_mode_i,
  input wire logic               stop_mode_i,
  input wire logic               irq_request_o,
  input wire logic               wakeup_o,
  input wire logic               branch_pin_level_o,
  input wire logic               pullup_enable_o,
  input wire logic               ext_int_pin_function_enable_o
);
  import eip_pkg::*;
  // All checks live in the one system clock domain
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wake_tie_a: assert property (
    wakeup_o == (irq_request_o && (wait_mode_i || stop_mode_i)))
    else $error("wakeup differs from request in low power");
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=>
    !irq_request_o && pullup_enable_o && !ext_int_pin_function_enable_o)
    else $error("reset left state behind");
  brch_dis_a: assert property (
    !ext_int_pin_function_enable_o |-> branch_pin_level_o)
    else $error("branch level not high while disabled");
  brch_lvl_a: assert property (ext_int_pin_function_enable_o |->
    branch_pin_level_o == $past(ext_int_pin_n_i, 2))
    else $error("branch level not the synchronised pin");
  ack_ro_a: assert property ($past(rd_i) &&
    $past(addr_i) == `EIP_OFS_STATUS_CONTROL |-> !rdata_o[`EIP_BIT_ACK])
    else $error("acknowledge field read back as one");
  pue_wr_a: assert property (wr_i && addr_i == `EIP_OFS_SECOND_CONFIG |=>
    pullup_enable_o == !$past(wdata_i[`EIP_BIT_PULLUP_DIS]))
    else $error("pull-up does not follow its disable bit");
  fen_wr_a: assert property (wr_i && addr_i == `EIP_OFS_SECOND_CONFIG |=>
    ext_int_pin_function_enable_o == $past(wdata_i[`EIP_BIT_FUNC_EN]))
    else $error("function enable does not follow its bit");
  mask_blk_a: assert property (wr_i && addr_i == `EIP_OFS_STATUS_CONTROL &&
    wdata_i[`EIP_BIT_MASK] |=> !irq_request_o)
    else $error("masked request still reaches the core");
endmodule
bind eip_unit eip_unit_sva eip_unit_sva_i (.*);
`default_nettype wire

// ===== testbench/eip_pin_src.sv
// Model of the external source that pulls the interrupt pin low
`default_nettype none
module eip_pin_src (
  input  wire logic clk_sys_i,   // System clock
  input  wire logic pull_low_i,  // Source pulls the pin low
  input  wire logic pullup_en_i, // Device pull-up connected
  output var logic  pin_n_o      // Level on the pin
);
  logic last; // Last level, shown inverted once floating
  // Remember the level so a floating pin never looks stable
  always_ff @(posedge clk_sys_i) begin
    last <= pin_n_o;
  end
  // Released pin is high only while the pull-up holds it
  assign pin_n_o = pull_low_i ? 1'b0 : (pullup_en_i ? 1'b1 : ~last);
endmodule
`default_nettype wire

// ===== testbench/eip_unit_bench.sv
// Self-checking bench for the external interrupt pin unit
`default_nettype none
module eip_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import eip_pkg::*;
  logic      clk, rst, wr, rd, vfa, brk, wt, stp, low; // Bench drives
  eip_addr_t addr;                                      // Register address
  eip_data_t wd;                                        // Write data
  logic [7:0] rdat;                                     // Read data
  logic      pin, irq, wake, bpl, pue, fen;             // Observed lines
  int        errors = 0;
  int        n_checks = 0;
  eip_pin_src eip_pin_src_i (.clk_sys_i(clk), .pull_low_i(low),
    .pullup_en_i(pue), .pin_n_o(pin));
  eip_unit eip_unit_i (.clk_sys_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .ext_int_pin_n_i(pin), .vector_fetch_ack_i(vfa), .break_state_i(brk),
    .wait_mode_i(wt), .stop_mode_i(stp), .irq_request_o(irq),
    .wakeup_o(wake), .branch_pin_level_o(bpl), .pullup_enable_o(pue),
    .ext_int_pin_function_enable_o(fen));
  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bit1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One-cycle write strobe, released at the next edge before returning
  task automatic wreg(input eip_addr_t a, input eip_data_t d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input eip_addr_t a, input eip_data_t e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
  endtask
  // Pin edges take three edges to reach the latch, so allow four
  task automatic pull(input logic l);
    @(posedge clk);
    low <= l;
    cyc(4);
  endtask
  task automatic s_reset();
    rchk(4'h0, 8'h00);
    rchk(4'h1, 8'h00);
    rchk(4'h2, 8'h00);
    rchk(4'h3, 8'h04);
    rchk(4'hf, 8'h00);
    bit1(bpl, 1'b1);
  endtask
  // Activity while disabled belongs to the port bit
  task automatic s_off();
    pull(1'b1);
    rchk(4'h3, 8'h00);
    bit1(irq, 1'b0);
    pull(1'b0);
  endtask
  task automatic s_edge();
    wreg(4'h1, 8'h02);
    pull(1'b1);
    bit1(irq, 1'b1);
    rchk(4'h0, 8'h08);
    rchk(4'h3, 8'h00);
    bit1(bpl, 1'b0);
    wreg(4'h0, 8'h04);
    rchk(4'h0, 8'h00);
  endtask
  // Low level keeps re-arming the latch; routine masks it
  task automatic s_level();
    wreg(4'h0, 8'h01);
    wreg(4'h0, 8'h05);
    rchk(4'h0, 8'h09);
    @(posedge clk);
    stp <= 1'b1;
    #1 bit1(wake, 1'b1);
    wreg(4'h0, 8'h03);
    #1 bit1(wake, 1'b0);
    @(posedge clk);
    {stp, wt} <= 2'b01;
    wreg(4'h0, 8'h01);
    #1 bit1(wake, 1'b1);
    @(posedge clk);
    wt <= 1'b0;
    pull(1'b0);
    wreg(4'h0, 8'h04);
    rchk(4'h0, 8'h00);
  endtask
  task automatic s_vec();
    pull(1'b1);
    pull(1'b0);
    vfa <= 1'b1;
    @(posedge clk);
    vfa <= 1'b0;
    #1 bit1(irq, 1'b0);
  endtask
  // Status survives acknowledge in break until clearing is enabled
  task automatic s_brk();
    @(posedge clk);
    brk <= 1'b1;
    pull(1'b1);
    pull(1'b0);
    wreg(4'h0, 8'h04);
    rchk(4'h0, 8'h08);
    wreg(4'h2, 8'h80);
    wreg(4'h0, 8'h04);
    brk <= 1'b0;
    rchk(4'h0, 8'h00);
    wreg(4'h1, 8'h03);
    #1 bit1(pue, 1'b0);
  endtask
  // Main sequence with an 8-cycle reset
  initial begin
    {rst, wr, rd, vfa, brk, wt, stp, low, addr, wd} = 20'h80000;
    cyc(8);
    rst <= 1'b0;
    s_reset();
    s_off();
    s_edge();
    s_level();
    s_vec();
    s_brk();
    end_of_test();
  end
  // Hang guard
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
